//--- hdl/ucc_usart_ctrl.sv
`timescale 1ns/1ps
`include "ucc_defs.svh"
module ucc_usart_ctrl #(
  parameter int ADDR_W      = 8,
  parameter int DATA_W      = 9,
  parameter int SYNC_CYCLES = `UCC_SYNC_CYC
) (
  input  wire logic              SYS_CLK,
  input  wire logic              RST_N,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  input  wire logic [3:0]        PSTRB,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  input  wire logic [DATA_W-1:0] TXW_DATA,
  input  wire logic              TXW_VALID,
  output logic                   TXW_READY,
  output logic      [DATA_W-1:0] TXE_DATA,
  output logic                   TXE_VALID,
  input  wire logic              TXE_READY,
  input  wire logic              TX_BUSY,
  input  wire logic              RX_START_EVT,
  input  wire logic              RX_DONE_EVT,
  input  wire logic              IRQ_RXS_EN,
  input  wire logic              IRQ_RXC_EN,
  output logic                   WAKE,
  output logic                   CORE_EN,
  output logic                   CLK_SRC_EXT,
  output logic                   CLK_SRC_INT,
  output logic                   RX_ON,
  output logic                   TX_ON,
  output logic                   RX_FLUSH,
  output logic                   PARITY_EN,
  output logic                   PARITY_ODD,
  output logic                   IRDA_EN,
  output logic                   SFD_EN,
  output logic                   COLL_DET_EN,
  output logic                   TWO_STOP,
  output logic      [3:0]        DATA_BITS,
  output logic      [15:0]       BAUD_INT,
  output logic      [2:0]        BAUD_FRAC,
  output logic                   DBG_STOP
);
  localparam int CW = $clog2(SYNC_CYCLES + 1);
  localparam logic [CW-1:0] SYNC_N = CW'(SYNC_CYCLES);
  // longest wait for a control-B sync: counter load, count, run
  localparam int PEND_MAX = SYNC_CYCLES + 2;

  if (SYNC_CYCLES < 1 || DATA_W < 5 || DATA_W > 32) begin : g_chk
    $error("ucc_usart_ctrl: unsupported parameter values");
  end

  typedef struct packed {
    ucc_pkg::ucc_srst_t srst;
    logic [CW-1:0]     sr_cnt;
    logic [2:0]        mode;
    logic [3:0]        form;
    logic [2:0]        oversample_rate_select;
    logic              en;
    logic              en_act;
    logic [CW-1:0]     en_cnt;
    logic              rx_req;
    logic              tx_req;
    logic              rx_run;
    logic              tx_run;
    logic [CW-1:0]     cb_cnt;
    logic              parity_kind;
    logic              line_encoding_select;
    logic              frame_start_wake_enable;
    logic              collision_detect_on;
    logic              stop_bit_count_select;
    logic [2:0]        character_width;
    logic [15:0]       baud;
    logic              dbg;
    logic [31:0]       rdata;
    logic              flush;
    logic              wake;
    logic [DATA_W-1:0] b0;
    logic [DATA_W-1:0] b1;
    logic [1:0]        bcnt;
  } ucc_st_t;

  ucc_st_t q;
  ucc_st_t n;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] w,
                                        input logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    return (o & ~m) | (w & m);
  endfunction : merge

  function automatic logic [3:0] width_of(input logic [2:0] c);
    case (c)
      3'h1:    return 4'h9;
      3'h5:    return 4'h5;
      3'h6:    return 4'h6;
      3'h7:    return 4'h7;
      default: return 4'h8;
    endcase
  endfunction : width_of

  logic        wr;
  logic        setup;
  logic        in_srst;
  logic        pend;
  logic        push;
  logic        pop;
  logic [31:0] ra;
  logic [31:0] rb;
  logic [31:0] rs;
  logic [31:0] va;
  logic [31:0] vb;
  logic [7:0]  ofs;

  assign wr      = PSEL && PENABLE && PWRITE;
  assign setup   = PSEL && !PENABLE && !PWRITE;
  assign ofs     = 8'(PADDR);
  assign in_srst = (q.srst == ucc_pkg::UCC_SRST);
  assign pend    = q.en_act && ((q.rx_req && !q.rx_run) || (q.tx_req && !q.tx_run));
  assign push    = TXW_VALID && TXW_READY;
  assign pop     = TXE_VALID && TXE_READY;

  // enable bits show the request while disabled, otherwise one only while both request and running state are set
  always_comb begin
    ra = `UCC_RST_WORD;
    ra[`UCC_A_SOFT_RESET_TRIGGER] = in_srst;
    ra[`UCC_A_EN] = q.en;
    ra[`UCC_A_MODE +: 3] = q.mode;
    ra[`UCC_A_OVERSAMPLE_RATE_SELECT +: 3] = q.oversample_rate_select;
    ra[`UCC_A_FORM +: 4] = q.form;
    rb = `UCC_RST_WORD;
    rb[`UCC_B_RX] = q.rx_req && (!q.en_act || q.rx_run);
    rb[`UCC_B_TX] = q.tx_req && (!q.en_act || q.tx_run);
    rb[`UCC_B_PM] = q.parity_kind;
    rb[`UCC_B_ENC] = q.line_encoding_select;
    rb[`UCC_B_SFD] = q.frame_start_wake_enable;
    rb[`UCC_B_COLD] = q.collision_detect_on;
    rb[`UCC_B_SBM] = q.stop_bit_count_select;
    rb[`UCC_B_CHSZ +: 3] = q.character_width;
    rs = `UCC_RST_WORD;
    rs[`UCC_S_SOFT_RESET_TRIGGER] = in_srst;
    rs[`UCC_S_EN] = (q.en_cnt != '0);
    rs[`UCC_S_CONTROL_B] = pend;
    va = merge(ra, PWDATA, PSTRB);
    vb = merge(rb, PWDATA, PSTRB);
  end

  always_comb begin
    n = q;
    n.flush = 1'b0;
    n.wake = q.frame_start_wake_enable && q.en_act &&
             ((RX_START_EVT && IRQ_RXS_EN) || (RX_DONE_EVT && IRQ_RXC_EN));
    if (setup) begin
      case (ofs)
        `UCC_OFS_CONTROL_A: n.rdata = ra;
        `UCC_OFS_CONTROL_B: n.rdata = rb;
        `UCC_OFS_BAUD:  n.rdata = {16'h0000, q.baud};
        `UCC_OFS_SYNCB: n.rdata = rs;
        `UCC_OFS_DBG:   n.rdata = {31'h0000_0000, q.dbg};
        default:        n.rdata = `UCC_RST_WORD;
      endcase
    end
    if (q.en_cnt != '0) begin
      n.en_cnt = q.en_cnt - 1'b1;
      if (q.en_cnt == CW'(1)) begin
        n.en_act = q.en;
      end
    end
    if (!q.en_act) begin
      n.rx_run = 1'b0;
      n.tx_run = 1'b0;
      n.cb_cnt = '0;
    end else if (q.cb_cnt != '0) begin
      n.cb_cnt = q.cb_cnt - 1'b1;
      if (q.cb_cnt == CW'(1)) begin
        n.rx_run = q.rx_req;
        n.tx_run = q.tx_req;
      end
    end else if (pend) begin
      n.cb_cnt = SYNC_N;
    end
    // transmitter holds on until queue and engine are both empty
    if (!q.tx_req && q.tx_run && q.bcnt == 2'd0 && !TX_BUSY) begin
      n.tx_run = 1'b0;
    end
    if (pop) begin
      n.b0 = q.b1;
    end
    if (push) begin
      if (q.bcnt == 2'd0 || (q.bcnt == 2'd1 && pop)) begin
        n.b0 = TXW_DATA;
      end else begin
        n.b1 = TXW_DATA;
      end
    end
    n.bcnt = q.bcnt + 2'(push) - 2'(pop);
    if (in_srst) begin
      n.sr_cnt = q.sr_cnt - 1'b1;
      if (q.sr_cnt == CW'(1)) begin
        n.srst = ucc_pkg::UCC_RUN;
      end
    end else if (wr && ofs == `UCC_OFS_CONTROL_A && va[`UCC_A_SOFT_RESET_TRIGGER]) begin
      n = '0;
      n.dbg = q.dbg;
      n.rdata = q.rdata;
      n.srst = ucc_pkg::UCC_SRST;
      n.sr_cnt = SYNC_N;
    end else if (wr) begin
      case (ofs)
        `UCC_OFS_CONTROL_A: begin
          if (!q.en) begin
            n.mode = va[`UCC_A_MODE +: 3];
            n.oversample_rate_select = va[`UCC_A_OVERSAMPLE_RATE_SELECT +: 3];
            n.form = va[`UCC_A_FORM +: 4];
          end
          n.en = va[`UCC_A_EN];
          if (va[`UCC_A_EN] != q.en) begin
            n.en_cnt = SYNC_N;
          end
        end
        `UCC_OFS_CONTROL_B: begin
          if (!q.en) begin
            n.parity_kind = vb[`UCC_B_PM];
            n.line_encoding_select = vb[`UCC_B_ENC];
            n.frame_start_wake_enable = vb[`UCC_B_SFD];
            n.collision_detect_on = vb[`UCC_B_COLD];
            n.stop_bit_count_select = vb[`UCC_B_SBM];
            n.character_width = vb[`UCC_B_CHSZ +: 3];
          end
          n.rx_req = vb[`UCC_B_RX];
          if (!vb[`UCC_B_RX]) begin
            n.rx_run = 1'b0;
            n.flush = 1'b1;
          end
          n.tx_req = vb[`UCC_B_TX];
        end
        `UCC_OFS_BAUD: begin
          if (!q.en) begin
            n.baud = va[15:0];
          end
        end
        `UCC_OFS_DBG: n.dbg = PWDATA[0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign PREADY      = 1'b1;
  assign PSLVERR     = wr && in_srst;
  assign PRDATA      = q.rdata;
  // refuse new words once transmitter is being turned off or reset runs
  assign TXW_READY   = (q.bcnt != 2'd2) && q.tx_req && !in_srst;
  assign TXE_VALID   = (q.bcnt != 2'd0) && q.tx_run;
  assign TXE_DATA    = q.b0;
  assign WAKE        = q.wake;
  assign CORE_EN     = q.en_act;
  assign CLK_SRC_EXT = q.mode == `UCC_MODE_EXT;
  assign CLK_SRC_INT = q.mode == `UCC_MODE_INT;
  assign RX_ON       = q.rx_run;
  assign TX_ON       = q.tx_run;
  assign RX_FLUSH    = q.flush;
  assign PARITY_EN   = q.form == `UCC_FORM_PAR || q.form == `UCC_FORM_ABPAR;
  assign PARITY_ODD  = q.parity_kind;
  assign IRDA_EN     = q.line_encoding_select;
  assign SFD_EN      = q.frame_start_wake_enable;
  assign COLL_DET_EN = q.collision_detect_on;
  assign TWO_STOP    = q.stop_bit_count_select;
  assign DATA_BITS   = width_of(q.character_width);
  assign BAUD_INT    = q.oversample_rate_select[0] ? {3'b000, q.baud[12:0]} : q.baud;
  assign BAUD_FRAC   = q.oversample_rate_select[0] ? q.baud[15:13] : 3'b000;
  assign DBG_STOP    = q.dbg;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  sequence s_trig;
    wr && !in_srst && ofs == `UCC_OFS_CONTROL_A && va[`UCC_A_SOFT_RESET_TRIGGER];
  endsequence
  sequence s_busy;
    in_srst && q.sr_cnt == SYNC_N;
  endsequence

  a_srst_hold: assert property (s_trig |=> s_busy)
    else $error("soft reset busy not started");
  a_srst_stay: assert property (in_srst && q.sr_cnt != CW'(1) |=> in_srst)
    else $error("soft reset ended early");
  a_srst_end: assert property (in_srst && q.sr_cnt == CW'(1) |=> !in_srst)
    else $error("soft reset did not end");
  a_srst_clear: assert property (s_trig |=> !q.en && q.baud == 16'h0000 && !q.rx_req)
    else $error("soft reset left state");
  a_srst_err: assert property (wr && in_srst |-> PSLVERR)
    else $error("write during reset not refused");
  a_en_sync: assert property ($rose(q.en) |-> q.en_cnt == SYNC_N && !q.en_act)
    else $error("enable sync not started");
  a_en_done: assert property (q.en_cnt == CW'(1) |=> q.en_act == $past(q.en))
    else $error("enable sync did not finish");
  a_rx_off: assert property (wr && !in_srst && ofs == `UCC_OFS_CONTROL_B && !vb[`UCC_B_RX]
                            && !va[`UCC_A_SOFT_RESET_TRIGGER] |=> RX_FLUSH && !RX_ON)
    else $error("receiver disable no flush");
  a_pend_zero: assert property (setup && ofs == `UCC_OFS_CONTROL_B && q.en_act && q.rx_req
                                && !q.rx_run |=> !PRDATA[`UCC_B_RX])
    else $error("pending enable reads one");
  a_pend_done: assert property ($rose(pend) |-> ##[1:PEND_MAX] !pend || !q.en_act)
    else $error("control sync never ends");
  a_tx_drain: assert property ($fell(TX_ON) && q.en_act |-> $past(q.bcnt) == 2'd0)
    else $error("transmitter stopped with queue");
  a_prot_baud: assert property (q.en && !in_srst |=> $stable(q.baud) || in_srst)
    else $error("baud changed while enabled");
endmodule : ucc_usart_ctrl

//--- hdl/ucc_defs.svh
`ifndef UCC_DEFS_SVH
`define UCC_DEFS_SVH
`define UCC_OFS_CONTROL_A   8'h00
`define UCC_OFS_CONTROL_B   8'h04
`define UCC_OFS_BAUD    8'h0C
`define UCC_OFS_SYNCB   8'h1C
`define UCC_OFS_DBG     8'h30
`define UCC_A_SOFT_RESET_TRIGGER     0
`define UCC_A_EN        1
`define UCC_A_MODE      2
`define UCC_A_OVERSAMPLE_RATE_SELECT     13
`define UCC_A_FORM      24
`define UCC_B_CHSZ      0
`define UCC_B_SBM       6
`define UCC_B_COLD      8
`define UCC_B_SFD       9
`define UCC_B_ENC       10
`define UCC_B_PM        13
`define UCC_B_TX        16
`define UCC_B_RX        17
`define UCC_S_SOFT_RESET_TRIGGER     0
`define UCC_S_EN        1
`define UCC_S_CONTROL_B     2
`define UCC_RST_WORD    32'h0000_0000
`define UCC_SYNC_CYC    4
`define UCC_MODE_EXT    3'h0
`define UCC_MODE_INT    3'h1
`define UCC_FORM_PAR    4'h1
`define UCC_FORM_ABPAR  4'h5
`endif

//--- hdl/ucc_pkg.sv
package ucc_pkg;
  typedef enum logic [0:0] {
    UCC_RUN  = 1'b0,
    UCC_SRST = 1'b1
  } ucc_srst_t;
endpackage : ucc_pkg

//--- tb/ucc_tx_model.sv
`timescale 1ns/1ps
module ucc_tx_model #(
  parameter int FRAME_CYC = 5
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [8:0] txe_data,
  input  wire logic       txe_valid,
  input  wire logic       stall,
  output logic            txe_ready,
  output logic            tx_busy
);
  logic [8:0] got_q[$];
  int         cnt_q;
  // engine takes no word while shifting, so the queue must hold it
  assign txe_ready = !stall && cnt_q == 0;
  assign tx_busy   = cnt_q != 0;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 0;
    end else if (txe_valid && txe_ready) begin
      got_q.push_back(txe_data);
      cnt_q <= FRAME_CYC;
    end else if (cnt_q != 0) begin
      cnt_q <= cnt_q - 1;
    end
  end
endmodule : ucc_tx_model

//--- tb/tb.sv
`timescale 1ns/1ps
module tb;
  logic        clk, rst_n, psel, penable, pwrite, txw_valid, stall, rand_stall, pushed, parity_error_flag;
  logic        rx_start, rx_done, rxs_en, rxc_en, txw_ready, txe_valid, txe_ready, tx_busy;
  logic        wake, core_en, clk_ext, clk_int, rx_on, tx_on, rx_flush, parity_en, parity_odd;
  logic        irda_en, sfd_en, coll_en, two_stop, dbg_stop;
  logic [7:0]  paddr;
  logic [7:0]  offs[6] = '{8'h00, 8'h04, 8'h0c, 8'h1c, 8'h20, 8'h30};
  logic [31:0] pwdata, prdata, rdata, v;
  logic [8:0]  txw_data, txe_data;
  logic [8:0]  exp_q[$];
  logic [3:0]  data_bits, form;
  logic [15:0] baud_int, bv;
  logic [2:0]  baud_frac;
  int          seed = 32'hd22c;
  int          err_total, checks, n, wake_cnt, flush_cnt;
  logic        parity_error_flag_w;

  ucc_usart_ctrl #(.SYNC_CYCLES(12)) uut (
    .SYS_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hf), .PRDATA(prdata), .PREADY(),
    .PSLVERR(parity_error_flag_w), .TXW_DATA(txw_data), .TXW_VALID(txw_valid), .TXW_READY(txw_ready),
    .TXE_DATA(txe_data), .TXE_VALID(txe_valid), .TXE_READY(txe_ready), .TX_BUSY(tx_busy),
    .RX_START_EVT(rx_start), .RX_DONE_EVT(rx_done), .IRQ_RXS_EN(rxs_en), .IRQ_RXC_EN(rxc_en),
    .WAKE(wake), .CORE_EN(core_en), .CLK_SRC_EXT(clk_ext), .CLK_SRC_INT(clk_int),
    .RX_ON(rx_on), .TX_ON(tx_on), .RX_FLUSH(rx_flush), .PARITY_EN(parity_en),
    .PARITY_ODD(parity_odd), .IRDA_EN(irda_en), .SFD_EN(sfd_en), .COLL_DET_EN(coll_en),
    .TWO_STOP(two_stop), .DATA_BITS(data_bits), .BAUD_INT(baud_int), .BAUD_FRAC(baud_frac),
    .DBG_STOP(dbg_stop));
  ucc_tx_model pm (.clk(clk), .rst_n(rst_n), .txe_data(txe_data), .txe_valid(txe_valid),
                   .stall(stall), .txe_ready(txe_ready), .tx_busy(tx_busy));

  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  always @(negedge clk) begin
    wake_cnt += (wake === 1'b1);
    flush_cnt += (rx_flush === 1'b1);
  end
  always @(posedge clk) if (rand_stall) #1 stall = $random(seed);

  task automatic complete_run();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    #1 {psel, penable, pwrite, paddr, pwdata} = {2'b10, wr, a, d};
    @(posedge clk);
    #1 penable = 1;
    @(negedge clk);
    rdata = prdata;
    parity_error_flag = parity_error_flag_w;
    @(posedge clk);
    #1 {psel, penable} = 2'b00;
  endtask : apb
  task automatic wait_sync();
    for (int i = 0; i < 30; i++) begin
      apb(0, 8'h1c, 32'h0);
      if (rdata === 32'h0) break;
    end
    chk(rdata, 32'h0);
  endtask : wait_sync
  task automatic push(input logic [8:0] d, input int lim);
    pushed = 0;
    @(posedge clk);
    #1 {txw_valid, txw_data} = {1'b1, d};
    for (int i = 0; i < lim && !pushed; i++) begin
      @(negedge clk);
      pushed = txw_ready;
      @(posedge clk);
    end
    #1 txw_valid = 0;
    if (pushed) exp_q.push_back(d);
  endtask : push
  task automatic pulse(input logic [1:0] en);
    @(posedge clk);
    #1 {rxc_en, rxs_en, rx_start} = {en, 1'b1};
    @(posedge clk);
    #1 {rx_start, rx_done} = 2'b01;
    @(posedge clk);
    #1 rx_done = 0;
    repeat (3) @(posedge clk);
  endtask : pulse
  task automatic reen(input logic [31:0] d, input int b);
    apb(1, 8'h04, d);
    apb(0, 8'h04, 32'h0);
    chk(rdata[b], 1'b0);
    apb(0, 8'h1c, 32'h0);
    chk(rdata[2], 1'b1);
    wait_sync();
    apb(0, 8'h04, 32'h0);
    chk(rdata[b], 1'b1);
  endtask : reen
  function automatic logic [3:0] exp_bits(input logic [2:0] c);
    case (c)
      3'h1: return 4'h9;
      3'h5, 3'h6, 3'h7: return {1'b0, c};
      default: return 4'h8;
    endcase
  endfunction : exp_bits

  initial begin
    {psel, penable, pwrite, paddr, pwdata, txw_valid, txw_data} = '0;
    {stall, rand_stall, rx_start, rx_done, rxs_en, rxc_en, rst_n} = '0;
    repeat (16) @(posedge clk);
    #1 rst_n = 1;
    foreach (offs[i]) begin
      apb(0, offs[i], 32'h0);
      chk(rdata, 32'h0);
    end
    chk({clk_ext, data_bits}, 5'h18);
    for (int m = 0; m < 2; m++) begin
      apb(1, 8'h00, 32'(m) << 2);
      chk({clk_ext, clk_int}, {m == 0, m == 1});
    end
    for (int i = 0; i < 3; i++) begin
      form = (i == 0) ? 4'h0 : (i == 1) ? 4'h1 : 4'h5;
      bv = $random(seed);
      apb(1, 8'h00, {4'h0, form, 10'h0, i[0], 13'h0});
      apb(1, 8'h0c, {16'h0, bv});
      apb(0, 8'h0c, 32'h0);
      chk(rdata, {16'h0, bv});
      chk(parity_en, i != 0);
      chk(baud_int, i[0] ? {3'h0, bv[12:0]} : bv);
      if (i[0]) chk(baud_frac, bv[15:13]);
    end
    for (int c = 0; c < 8; c++) begin
      v = $random(seed);
      v[2:0] = c[2:0];
      apb(1, 8'h04, v);
      apb(0, 8'h04, 32'h0);
      chk(rdata, v & 32'h0003_2747);
      chk(data_bits, exp_bits(c[2:0]));
      chk({parity_odd, irda_en, sfd_en, coll_en, two_stop}, {v[13], v[10:8], v[6]});
    end
    apb(1, 8'h30, 32'h1);
    apb(1, 8'h04, 32'h0003_0200);
    apb(1, 8'h00, 32'h0100_0006);
    apb(0, 8'h00, 32'h0);
    chk(rdata, 32'h0100_0006);
    apb(0, 8'h1c, 32'h0);
    chk(rdata[2:1], 2'h1);
    for (int i = 0; i < 10 && rdata[1]; i++) apb(0, 8'h1c, 32'h0);
    chk(rdata[2:1], 2'h2);
    apb(0, 8'h04, 32'h0);
    chk(rdata[17:16], 2'h0);
    wait_sync();
    apb(0, 8'h04, 32'h0);
    chk(rdata[17:16], 2'h3);
    chk({core_en, rx_on, tx_on}, 3'h7);
    apb(1, 8'h04, 32'h0003_0205);
    apb(1, 8'h0c, 32'h0000_1234);
    apb(1, 8'h00, 32'h0000_0002);
    apb(0, 8'h0c, 32'h0);
    chk(rdata, {16'h0, bv});
    chk({data_bits, clk_int, parity_en}, 6'h23);
    wait_sync();
    for (int k = 0; k < 4; k++) begin
      wake_cnt = 0;
      pulse(k[1:0]);
      chk(wake_cnt, 32'(k[0]) + 32'(k[1]));
    end
    #1 stall = 1;
    n = 0;
    for (int i = 0; i < 4; i++) begin
      push(9'(i + 3), 8);
      n += pushed;
    end
    chk(n, 2);
    apb(1, 8'h04, 32'h0002_0200);
    repeat (4) @(negedge clk);
    chk(tx_on, 1'b1);
    @(posedge clk);
    #1 stall = 0;
    for (int i = 0; i < 100 && tx_on; i++) @(negedge clk);
    chk({tx_busy, txw_ready, 30'(pm.got_q.size())}, 32'h2);
    wait_sync();
    reen(32'h0003_0200, 16);
    rand_stall = 1;
    for (int i = 0; i < 12; i++) push(9'($random(seed)), 50);
    rand_stall = 0;
    @(posedge clk);
    #1 stall = 0;
    for (int i = 0; i < 400 && pm.got_q.size() < exp_q.size(); i++) @(negedge clk);
    chk(pm.got_q.size(), exp_q.size());
    foreach (exp_q[i]) chk(pm.got_q[i], exp_q[i]);
    flush_cnt = 0;
    apb(1, 8'h04, 32'h0001_0200);
    for (int i = 0; i < 40 && rx_on; i++) @(negedge clk);
    repeat (2) @(negedge clk);
    chk({rx_on, 31'(flush_cnt)}, 32'h1);
    wait_sync();
    reen(32'h0003_0200, 17);
    apb(1, 8'h00, 32'h0100_0007);
    apb(0, 8'h00, 32'h0);
    chk(rdata, 32'h1);
    apb(0, 8'h1c, 32'h0);
    chk(rdata, 32'h1);
    apb(1, 8'h0c, 32'h0000_00ff);
    chk(parity_error_flag, 1'b1);
    apb(0, 8'h04, 32'h0);
    chk(rdata, 32'h0);
    wait_sync();
    apb(0, 8'h00, 32'h0);
    chk(rdata, 32'h0);
    apb(0, 8'h0c, 32'h0);
    chk(rdata, 32'h0);
    chk({core_en, rx_on, tx_on, clk_ext, parity_en, dbg_stop}, 6'h05);
    complete_run();
  end
  initial begin
    #100000;
    err_total++;
    complete_run();
  end
endmodule : tb
